// ==== logic/bchu_regs.sv ====
// Upper configuration header bank of the bridge, offsets 32h to 3Eh
// Operation
// - Top-of-I/O-window upper address bits, 16-bit read/write, reset zero.
// - First capability offset reads fixed DCh; writes ignored.
// - ROM window base is 32-bit zero, writes ignored.
// - Interrupt routing byte is read/write and resets to FFh.
// - Interrupt terminal byte is read-only zero.
// - Secondary control at 3Eh, all bits zero after reset.
// - Secondary control bits 15 to 12 read zero, writes dropped.
// - Control bit 11 enables system error on primary discard expiry.
// - Bit 10 set on any discard; software clears by writing one.
// - Discard wait is 2^15 clocks, or 2^10 when select bit set.
`timescale 1ns/100ps
`include "bchu_params.svh"
module bchu_regs
    import bchu_pkg::*;
#(
    parameter int LONG_WAIT  = `BCHU_WAIT_LONG,
    parameter int SHORT_WAIT = `BCHU_WAIT_SHORT
) (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic        cfg_req,
    input  wire logic        cfg_we,
    input  wire logic [5:0]  cfg_dw,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    input  wire logic        pri_pend,
    input  wire logic        sec_pend,
    output logic             cfg_ack,
    output logic [31:0]      cfg_rdata,
    output logic [15:0]      io_top_hi,
    output logic [15:0]      sec_ctrl,
    output logic [7:0]       irq_route,
    output logic             pri_discard,
    output logic             sec_discard,
    output logic             discard_serr
);
    logic        rst_meta_r;
    logic        rst_n;
    logic        wr;
    logic        rd;
    logic        hit_io;
    logic        hit_cap;
    logic        hit_rom;
    logic        hit_irq;
    logic        stat_clr;
    bchu_half_t  ctrl_nxt;
    bchu_word_t  rdata_nxt;

    // Bank dword index of a printed byte offset
    function automatic bchu_dword_t dw_of(input bchu_byte_t off);
        dw_of = off[7:2];
    endfunction

    // Merge two write bytes into a half-word under their enables
    function automatic bchu_half_t merge16(input bchu_half_t old,
                                           input bchu_half_t nw,
                                           input logic [1:0] be);
        merge16 = {be[1] ? nw[15:8] : old[15:8],
                   be[0] ? nw[7:0]  : old[7:0]};
    endfunction

    // Reset is applied at once and released on the clock
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    assign wr      = ce && cfg_req && cfg_we;
    assign rd      = ce && cfg_req && !cfg_we;
    assign hit_io  = cfg_dw == dw_of(`BCHU_OFF_IO_TOP_HI);
    assign hit_cap = cfg_dw == dw_of(`BCHU_OFF_CAP_FIRST);
    assign hit_rom = cfg_dw == dw_of(`BCHU_OFF_ROM_BASE);
    assign hit_irq = cfg_dw == dw_of(`BCHU_OFF_IRQ_ROUTE);

    // Top of I/O window, upper half of dword 30h
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            io_top_hi <= `BCHU_RST_IO_TOP_HI;
        end else if (wr && hit_io) begin
            io_top_hi <= merge16(io_top_hi, cfg_wdata[31:16],
                                 cfg_be[3:2]);
        end
    end

    // Interrupt routing byte; the terminal byte beside it has no storage
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_route <= `BCHU_RST_IRQ_ROUTE;
        end else if (wr && hit_irq && cfg_be[0]) begin
            irq_route <= cfg_wdata[7:0];
        end
    end

    // Secondary control; a status set in the clearing cycle wins
    assign stat_clr = wr && hit_irq && cfg_be[3] &&
                      cfg_wdata[16 + `BCHU_CTRL_DISC_STAT];

    always_comb begin
        ctrl_nxt = sec_ctrl;
        if (wr && hit_irq) begin
            ctrl_nxt = (merge16(sec_ctrl, cfg_wdata[31:16], cfg_be[3:2])
                        & `BCHU_CTRL_RW_MASK)
                     | (sec_ctrl & ~`BCHU_CTRL_RW_MASK);
        end
        if (stat_clr) begin
            ctrl_nxt[`BCHU_CTRL_DISC_STAT] = 1'b0;
        end
        if (pri_discard || sec_discard) begin
            ctrl_nxt[`BCHU_CTRL_DISC_STAT] = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_ctrl <= `BCHU_RST_SEC_CTRL;
        end else if (ce) begin
            sec_ctrl <= ctrl_nxt;
        end
    end

    // Primary and secondary timers share one design, each with its select
    bchu_discard_timer #(
        .LONG_WAIT  (LONG_WAIT),
        .SHORT_WAIT (SHORT_WAIT)
    ) u_pri_timer (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .pend      (pri_pend),
        .short_sel (sec_ctrl[`BCHU_CTRL_PRI_SHORT]),
        .expire    (pri_discard)
    );

    bchu_discard_timer #(
        .LONG_WAIT  (LONG_WAIT),
        .SHORT_WAIT (SHORT_WAIT)
    ) u_sec_timer (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .pend      (sec_pend),
        .short_sel (sec_ctrl[`BCHU_CTRL_SEC_SHORT]),
        .expire    (sec_discard)
    );

    // Only primary expiry may raise system error
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            discard_serr <= 1'b0;
        end else if (ce) begin
            discard_serr <= pri_discard &&
                            sec_ctrl[`BCHU_CTRL_SERR_EN];
        end
    end

    // Read mux; dwords outside the bank read zero
    always_comb begin
        rdata_nxt = 32'h00000000;
        if (hit_io) begin
            rdata_nxt = {io_top_hi, 16'h0000};
        end else if (hit_cap) begin
            rdata_nxt = {24'h000000, `BCHU_VAL_CAP_FIRST};
        end else if (hit_rom) begin
            rdata_nxt = `BCHU_VAL_ROM_BASE;
        end else if (hit_irq) begin
            rdata_nxt = {sec_ctrl & `BCHU_CTRL_RW_MASK
                         | (sec_ctrl & 16'h0400),
                         `BCHU_VAL_IRQ_TERM, irq_route};
        end
    end

    // Answer one enabled cycle after the request, read or write
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ack   <= 1'b0;
            cfg_rdata <= 32'h00000000;
        end else if (ce) begin
            cfg_ack <= cfg_req;
            if (rd) begin
                cfg_rdata <= rdata_nxt;
            end
        end
    end

    property p_io_write;
        @(posedge core_clk) disable iff (!rst_n)
        wr && hit_io && cfg_be[3:2] == 2'b11
        |=> io_top_hi == $past(cfg_wdata[31:16]);
    endproperty
    a_io_write: assert property (p_io_write)
        else $error("I/O window top did not take a full write");

    property p_cap_read;
        @(posedge core_clk) disable iff (!rst_n)
        rd && hit_cap |=> cfg_ack && cfg_rdata == 32'h000000dc;
    endproperty
    a_cap_read: assert property (p_cap_read)
        else $error("capability offset read wrong");

    property p_rom_read;
        @(posedge core_clk) disable iff (!rst_n)
        rd && hit_rom |=> cfg_rdata == 32'h00000000;
    endproperty
    a_rom_read: assert property (p_rom_read)
        else $error("ROM window base not zero");

    property p_route_write;
        @(posedge core_clk) disable iff (!rst_n)
        wr && hit_irq && cfg_be[0] |=> irq_route == $past(cfg_wdata[7:0]);
    endproperty
    a_route_write: assert property (p_route_write)
        else $error("interrupt routing byte did not store");

    property p_term_read;
        @(posedge core_clk) disable iff (!rst_n)
        rd && hit_irq |=> cfg_rdata[15:8] == 8'h00
                          && cfg_rdata[31:28] == 4'h0;
    endproperty
    a_term_read: assert property (p_term_read)
        else $error("terminal byte or reserved bits read nonzero");

    property p_ctrl_reset;
        @(posedge core_clk)
        $rose(rst_n) |-> sec_ctrl == 16'h0000 && irq_route == 8'hff;
    endproperty
    a_ctrl_reset: assert property (p_ctrl_reset)
        else $error("reset values wrong after release");

    property p_reserved_keep;
        @(posedge core_clk) disable iff (!rst_n)
        wr && hit_irq |=> sec_ctrl[15:12] == 4'h0;
    endproperty
    a_reserved_keep: assert property (p_reserved_keep)
        else $error("reserved control bits took a write");

    property p_serr;
        @(posedge core_clk) disable iff (!rst_n)
        ce && pri_discard
        |=> discard_serr == $past(sec_ctrl[`BCHU_CTRL_SERR_EN]);
    endproperty
    a_serr: assert property (p_serr)
        else $error("system error not tied to enable bit");

    property p_stat_set;
        @(posedge core_clk) disable iff (!rst_n)
        ce && (pri_discard || sec_discard) |=> sec_ctrl[10];
    endproperty
    a_stat_set: assert property (p_stat_set)
        else $error("discard status not set by expiry");

    property p_stat_clear;
        @(posedge core_clk) disable iff (!rst_n)
        stat_clr && !pri_discard && !sec_discard |=> !sec_ctrl[10];
    endproperty
    a_stat_clear: assert property (p_stat_clear)
        else $error("write of one did not clear status");

    property p_ro_write;
        @(posedge core_clk) disable iff (!rst_n)
        wr && (hit_cap || hit_rom) |=> $stable(io_top_hi)
                                       && $stable(irq_route);
    endproperty
    a_ro_write: assert property (p_ro_write)
        else $error("read-only write disturbed stored values");

    property p_be_keep;
        @(posedge core_clk) disable iff (!rst_n)
        wr && hit_io && cfg_be[3:2] == 2'b01
        |=> io_top_hi[15:8] == $past(io_top_hi[15:8]);
    endproperty
    a_be_keep: assert property (p_be_keep)
        else $error("disabled byte lane was written");

    property p_io_read;
        @(posedge core_clk) disable iff (!rst_n)
        rd && hit_io |=> cfg_rdata == {$past(io_top_hi), 16'h0000};
    endproperty
    a_io_read: assert property (p_io_read)
        else $error("I/O window top read back wrong");

    property p_serr_write;
        @(posedge core_clk) disable iff (!rst_n)
        wr && hit_irq && cfg_be[3]
        |=> sec_ctrl[`BCHU_CTRL_SERR_EN]
            == $past(cfg_wdata[16 + `BCHU_CTRL_SERR_EN]);
    endproperty
    a_serr_write: assert property (p_serr_write)
        else $error("system error enable did not take a write");

    property p_serr_quiet;
        @(posedge core_clk) disable iff (!rst_n)
        ce && !pri_discard |=> !discard_serr;
    endproperty
    a_serr_quiet: assert property (p_serr_quiet)
        else $error("system error raised without primary expiry");

    property p_route_keep;
        @(posedge core_clk) disable iff (!rst_n)
        wr && hit_irq && !cfg_be[0] |=> $stable(irq_route);
    endproperty
    a_route_keep: assert property (p_route_keep)
        else $error("routing byte changed with its lane disabled");
endmodule // bchu_regs

// ==== logic/bchu_params.svh ====
// Offsets, field positions, reset values and counts of the upper header bank
`ifndef BCHU_PARAMS_SVH
`define BCHU_PARAMS_SVH

`define BCHU_OFF_IO_TOP_HI     8'h32
`define BCHU_OFF_CAP_FIRST     8'h34
`define BCHU_OFF_ROM_BASE      8'h38
`define BCHU_OFF_IRQ_ROUTE     8'h3c
`define BCHU_OFF_IRQ_TERM      8'h3d
`define BCHU_OFF_SEC_CTRL      8'h3e

`define BCHU_RST_IO_TOP_HI     16'h0000
`define BCHU_VAL_CAP_FIRST     8'hdc
`define BCHU_VAL_ROM_BASE      32'h00000000
`define BCHU_RST_IRQ_ROUTE     8'hff
`define BCHU_VAL_IRQ_TERM      8'h00
`define BCHU_RST_SEC_CTRL      16'h0000

`define BCHU_CTRL_RW_MASK      16'h0b6f
`define BCHU_CTRL_SERR_EN      11
`define BCHU_CTRL_DISC_STAT    10
`define BCHU_CTRL_SEC_SHORT    9
`define BCHU_CTRL_PRI_SHORT    8

`define BCHU_WAIT_LONG         32768
`define BCHU_WAIT_SHORT        1024

`endif

// ==== logic/bchu_pkg.sv ====
// Types shared by the upper header bank and its discard timers
package bchu_pkg;
    typedef logic [7:0]  bchu_byte_t;
    typedef logic [15:0] bchu_half_t;
    typedef logic [31:0] bchu_word_t;
    typedef logic [5:0]  bchu_dword_t;
    typedef logic [15:0] bchu_count_t;
    typedef enum logic [1:0] {
        BCHU_TMR_IDLE  = 2'b01,
        BCHU_TMR_COUNT = 2'b10
    } bchu_tmr_e;
endpackage

// ==== logic/bchu_discard_timer.sv ====
// Discard timer for one side's pending delayed request
`timescale 1ns/100ps
module bchu_discard_timer
    import bchu_pkg::*;
#(
    parameter int LONG_WAIT  = 32768,
    parameter int SHORT_WAIT = 1024
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic pend,
    input  wire logic short_sel,
    output logic      expire
);
    bchu_tmr_e   state_r;
    bchu_count_t cnt_r;
    bchu_count_t last;

    assign last = short_sel ? bchu_count_t'(SHORT_WAIT - 1)
                            : bchu_count_t'(LONG_WAIT - 1);

    // Goes idle after firing; a pend still high starts a fresh full wait
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= BCHU_TMR_IDLE;
            cnt_r   <= 16'h0000;
            expire  <= 1'b0;
        end else if (ce) begin
            expire <= 1'b0;
            case (state_r)
                BCHU_TMR_IDLE: begin
                    cnt_r <= 16'h0000;
                    if (pend) begin
                        state_r <= BCHU_TMR_COUNT;
                    end
                end
                BCHU_TMR_COUNT: begin
                    if (!pend) begin
                        state_r <= BCHU_TMR_IDLE;
                    end else if (cnt_r >= last) begin
                        expire  <= 1'b1;
                        state_r <= BCHU_TMR_IDLE;
                    end else begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
                default: state_r <= BCHU_TMR_IDLE;
            endcase
        end
    end

    property p_expire_at_limit;
        @(posedge core_clk) disable iff (!rst_n)
        ce && pend && state_r == BCHU_TMR_COUNT && cnt_r >= last
        |=> expire;
    endproperty
    a_expire_at_limit: assert property (p_expire_at_limit)
        else $error("timer did not expire at its limit");

    property p_no_early_expire;
        @(posedge core_clk) disable iff (!rst_n)
        ce && state_r == BCHU_TMR_COUNT && cnt_r < last |=> !expire;
    endproperty
    a_no_early_expire: assert property (p_no_early_expire)
        else $error("timer expired before its limit");
endmodule // bchu_discard_timer

// ==== tb/bchu_host.sv ====
// Host model issuing configuration reads and writes to the bank
`timescale 1ns/100ps
module bchu_host
    import bchu_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        cfg_ack,
    input  wire logic [31:0] cfg_rdata,
    output logic             cfg_req,
    output logic             cfg_we,
    output logic [5:0]       cfg_dw,
    output logic [3:0]       cfg_be,
    output logic [31:0]      cfg_wdata
);
    initial begin
        cfg_req = 1'b0;
        cfg_we = 1'b0;
        cfg_dw = 6'h3f;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0;
    end

    // Strobe is one cycle; qualifiers held until the answer is seen
    task automatic access(input logic we, input logic [5:0] dw,
                          input logic [3:0] be, input logic [31:0] wd,
                          output logic [31:0] rd, output logic ok);
        int i;
        ok = 1'b0;
        rd = 32'h0;
        @(negedge core_clk);
        cfg_req <= 1'b1;
        cfg_we <= we;
        cfg_dw <= dw;
        cfg_be <= be;
        cfg_wdata <= wd;
        for (i = 0; i < 8 && !ok; i++) begin
            @(negedge core_clk);
            cfg_req <= 1'b0;
            if (cfg_ack === 1'b1) begin
                ok = 1'b1;
                rd = cfg_rdata;
            end
        end
        // Released we, dw and wdata show the inverse and byte enables clear, so stale values never pass
        @(negedge core_clk);
        cfg_we <= ~we;
        cfg_dw <= ~dw;
        cfg_be <= 4'h0;
        cfg_wdata <= ~wd;
    endtask
endmodule // bchu_host

// ==== tb/bridge_config_header_upper_test.sv ====
// Self-checking bench for the upper configuration header bank
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module bridge_config_header_upper_test;
    import bchu_pkg::*;
    logic        core_clk, resetn, ce, pri_pend, sec_pend;
    logic        cfg_req, cfg_we, cfg_ack;
    logic [5:0]  cfg_dw;
    logic [3:0]  cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic [15:0] io_top_hi, sec_ctrl;
    logic [7:0]  irq_route;
    logic        pri_discard, sec_discard, discard_serr;
    int          n_mismatch = 0;
    int          n_compared = 0;

    bchu_regs #(.LONG_WAIT(16), .SHORT_WAIT(4)) dut (
        .core_clk(core_clk), .resetn(resetn), .ce(ce), .cfg_req(cfg_req),
        .cfg_we(cfg_we), .cfg_dw(cfg_dw), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata), .pri_pend(pri_pend), .sec_pend(sec_pend),
        .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .io_top_hi(io_top_hi),
        .sec_ctrl(sec_ctrl), .irq_route(irq_route),
        .pri_discard(pri_discard), .sec_discard(sec_discard),
        .discard_serr(discard_serr));

    bchu_host host (
        .core_clk(core_clk), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
        .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_dw(cfg_dw),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));

    initial core_clk = 1'b0;
    always #50 core_clk = ~core_clk;

    task automatic test_done();
        $display("mismatches %0d of %0d compared", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic xfer(input logic we, input logic [5:0] dw,
                        input logic [3:0] be, input logic [31:0] wd,
                        output logic [31:0] rd);
        logic ok;
        host.access(we, dw, be, wd, rd, ok);
        `CHK(ok, 1'b1)
        if (ok !== 1'b1)
            test_done();
    endtask

    task automatic wr(input logic [5:0] dw, input logic [3:0] be,
                      input logic [31:0] wd);
        logic [31:0] rd;
        xfer(1'b1, dw, be, wd, rd);
    endtask

    task automatic rdchk(input logic [5:0] dw, input logic [31:0] exp);
        logic [31:0] rd;
        xfer(1'b0, dw, 4'hf, 32'h0, rd);
        `CHK(rd, exp)
    endtask

    task automatic t_defaults();
        `CHK(io_top_hi, 16'h0000)
        `CHK(irq_route, 8'hff)
        `CHK(sec_ctrl, 16'h0000)
        rdchk(6'h0c, 32'h00000000);
        rdchk(6'h0d, 32'h000000dc);
        rdchk(6'h0e, 32'h00000000);
        rdchk(6'h0f, 32'h000000ff);
    endtask

    task automatic t_window_top();
        wr(6'h0c, 4'b1100, 32'ha5a51234);
        `CHK(io_top_hi, 16'ha5a5)
        wr(6'h0c, 4'b0100, 32'hffc3ffff);
        `CHK(io_top_hi, 16'ha5c3)
        wr(6'h0c, 4'b0011, 32'hffffffff);
        rdchk(6'h0c, 32'ha5c30000);
    endtask

    task automatic t_read_only();
        wr(6'h0d, 4'hf, 32'hffffffff);
        wr(6'h0e, 4'hf, 32'hffffffff);
        wr(6'h10, 4'hf, 32'hffffffff);
        rdchk(6'h0d, 32'h000000dc);
        rdchk(6'h0e, 32'h00000000);
        rdchk(6'h10, 32'h00000000);
    endtask

    task automatic t_control();
        wr(6'h0f, 4'b0011, 32'h0000ff12);
        `CHK(irq_route, 8'h12)
        wr(6'h0f, 4'b1100, 32'hffffffff);
        `CHK(sec_ctrl, 16'h0b6f)
        rdchk(6'h0f, 32'h0b6f0012);
        wr(6'h0f, 4'b1000, 32'h00000000);
        `CHK(sec_ctrl, 16'h006f)
        `CHK(irq_route, 8'h12)
        wr(6'h0f, 4'b0100, 32'h00000000);
        `CHK(sec_ctrl, 16'h0000)
    endtask

    // Pend held until expiry; the count window allows for the start edge
    task automatic t_timer(input logic sh, input logic en, input logic pri);
        int n;
        int lim;
        logic hit;
        lim = sh ? 4 : 16;
        hit = 1'b0;
        wr(6'h0f, 4'b1100, {4'h0, en, 1'b0, ~pri & sh, pri & sh, 24'h000000});
        @(negedge core_clk);
        pri_pend = pri;
        sec_pend = ~pri;
        for (n = 1; n < 40 && !hit; n++) begin
            @(posedge core_clk);
            #1;
            hit = pri ? pri_discard : sec_discard;
        end
        `CHK(hit, 1'b1)
        `CHK((n - 1 >= lim) && (n - 1 <= lim + 3), 1'b1)
        if (hit !== 1'b1)
            test_done();
        @(posedge core_clk);
        #1;
        `CHK(discard_serr, pri & en)
        `CHK(sec_ctrl[10], 1'b1)
        @(negedge core_clk);
        pri_pend = 1'b0;
        sec_pend = 1'b0;
        wr(6'h0f, 4'b1000, 32'h00000000);
        `CHK(sec_ctrl[10], 1'b1)
        wr(6'h0f, 4'b1000, 32'h04000000);
        `CHK(sec_ctrl[10], 1'b0)
    endtask

    initial begin
        resetn = 1'b0;
        ce = 1'b1;
        pri_pend = 1'b0;
        sec_pend = 1'b0;
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
        resetn = 1'b1;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        t_defaults();
        t_window_top();
        t_read_only();
        t_control();
        t_timer(1'b1, 1'b1, 1'b1);
        t_timer(1'b0, 1'b0, 1'b1);
        t_timer(1'b0, 1'b1, 1'b0);
        t_timer(1'b1, 1'b0, 1'b0);
        test_done();
    end
endmodule // bridge_config_header_upper_test
